//--- hw/sicp_control_port.sv
`timescale 1ns/1ps
// What this block does
// R1 - Address LSB zero selects write, one selects read.
// R2 - Answers one of four addresses; two low bits come from the select pins.
// R3 - Pulls data low in the ack slot after a matching address.
// R4 - Pulls data low in the ack slot after each written byte.
// R5 - First data bit zero means ratio byte, one means control.
// R6 - Applies data at end of second ratio, control and band bytes.
// R7 - Both ratio bytes apply together, never after the first alone.
// R8 - Keeps taking data bytes without new address until STOP.
// R9 - Aborted write keeps earlier settings, drops the partial byte.
// R10 - Ratio bits 14..8 from first byte, 7..0 second, 15 control.
// R11 - Control bits 4 and 5 choose one of four pump currents.
// R12 - Control bit 7 picks reference divide by 128 or 64.
// R13 - Control bit 8 zero enables tuning amp, one disables it.
// R14 - Band byte bits 1 to 3 select the test mode.
// R15 - Band bit 5 drives second band output, bit 8 the first.
// R16 - Read returns one status byte with flags, comparators, code.
// R17 - Power flag set at power-up or supply loss, cleared after read.
// R18 - Status bit 2 shows loop lock, one when locked.
// R19 - Status bits 3..5 carry comparator ports 3, 2, 1.
// R20 - Status bits 6..8 carry converter code, MSB first.
// R21 - Test code decodes to pump off, sink, source, monitors, phase.
// R22 - Converter code runs 000 to 100 with rising input voltage.
// R23 - Any active test mode forces the tuning amp control to normal.
// R24 - Don't-care bits ignored; status shifted out MSB first.
// R25 - Reset gives ratio zero, bands off, amp off, lowest pump.
module sicp_control_port (
  input  wire logic        CORE_CLK_IN,          // Core clock, 250 MHz
  input  wire logic        RST_N_IN,             // Sync reset, active low
  input  wire logic        SCL_IN,               // Bus clock pin
  input  wire logic        SDA_IN,               // Bus data pin level
  output logic             SDA_OUT,              // Data drive value
  output logic             SDA_OE_OUT,           // High: pull data low
  input  wire logic [1:0]  ADDR_SEL_IN,          // Address select pins
  input  wire logic        LOCK_FLAG_IN,         // Loop locked
  input  wire logic        COMPARATOR_IN_1_IN,   // Comparator port 1
  input  wire logic        COMPARATOR_IN_2_IN,   // Comparator port 2
  input  wire logic        COMPARATOR_IN_3_IN,   // Comparator port 3
  input  wire logic [2:0]  LEVEL_CODE_IN,        // Five-level code
  input  wire logic        SUPPLY_OK_IN,         // Supply at least 3 V
  output logic [15:0]      RATIO_OUT,            // Counter ratio
  output logic [1:0]       PUMP_CURRENT_OUT,     // Pump current code
  output logic             REF_DIVIDE_SELECT_OUT,// 0: /128, 1: /64
  output logic             TUNING_AMP_OFF_OUT,   // High: amp off
  output logic [2:0]       TEST_SEL_OUT,         // Raw test code
  output logic             PUMP_OFF_OUT,         // Test: pump off
  output logic             SINK_ONLY_OUT,        // Test: sink only
  output logic             SOURCE_ONLY_OUT,      // Test: source only
  output logic             REF_MONITOR_OUT,      // Test: reference out
  output logic             HALF_DIV_MONITOR_OUT, // Test: half counter
  output logic             PHASE_TEST_OUT,       // Test: phase compare
  output logic             BAND_OUT_FIRST_OUT,   // First band output
  output logic             BAND_OUT_SECOND_OUT   // Second band output
);

  typedef struct packed {
    sicp_pkg::sicp_bus_t st;
    sicp_pkg::sicp_exp_t exp_kind;
    logic                rw;
    logic [7:0]          shreg;
    logic [3:0]          bit_cnt;
    logic                sda_oe;
    logic                scl_d;
    logic                sda_d;
    logic [6:0]          ratio_hi;
    logic [15:0]         ratio;
    logic [1:0]          pump;
    logic                ref_div;
    logic                amp_off;
    logic                amp_eff;
    logic [2:0]          test;
    logic [5:0]          mode;
    logic                band_first;
    logic                band_second;
    logic                por;
  } sicp_core_t;

  sicp_core_t  q_ff;
  sicp_core_t  nxt_q;
  sicp_pin_if  pins ();
  logic        scl;
  logic        sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        byte_done;
  logic [2:0]  level;
  logic [7:0]  status;

  // Address match against the fixed part and the select pins
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [1:0] sel);
    addr_match = (b[7:1] == {sicp_pkg::ADDR_FIXED, sel});
  endfunction

  // Test code to one-hot mode flags; 000 gives all zero
  function automatic logic [5:0] test_decode(input logic [2:0] t);
    test_decode[0] = (t[2:1] == 2'h1);                // see R21
    test_decode[1] = (t == sicp_pkg::TM_SINK);
    test_decode[2] = (t == sicp_pkg::TM_SOURCE);
    test_decode[3] = (t == sicp_pkg::TM_REF);
    test_decode[4] = (t == sicp_pkg::TM_HALF);
    test_decode[5] = (t == sicp_pkg::TM_PHASE);
  endfunction

  // All pins pass the three-stage sampler before use
  assign pins.raw = {SUPPLY_OK_IN, LEVEL_CODE_IN, COMPARATOR_IN_3_IN,
                     COMPARATOR_IN_2_IN, COMPARATOR_IN_1_IN,
                     LOCK_FLAG_IN, ADDR_SEL_IN, SDA_IN, SCL_IN};

  sicp_pin_sampler u_sampler (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .pins     (pins.sampler)
  );

  // Bus events from filtered levels
  assign scl       = pins.lvl[sicp_pkg::IX_SCL];
  assign sda       = pins.lvl[sicp_pkg::IX_SDA];
  assign scl_rise  = scl & ~q_ff.scl_d;
  assign scl_fall  = ~scl & q_ff.scl_d;
  assign start_ev  = scl & q_ff.scl_d & q_ff.sda_d & ~sda;
  assign stop_ev   = scl & q_ff.scl_d & ~q_ff.sda_d & sda;
  assign byte_done = scl_fall & (q_ff.bit_cnt == sicp_pkg::BYTE_DONE_CNT);

  // Out-of-range converter codes are clamped to the top band
  assign level = (pins.lvl[sicp_pkg::IX_LVL +: 3] > sicp_pkg::LEVEL_MAX)
               ? sicp_pkg::LEVEL_MAX
               : pins.lvl[sicp_pkg::IX_LVL +: 3];             // see R22

  // Status byte assembled live, captured when a read byte is loaded
  assign status = {q_ff.por,                                  // see R16
                   pins.lvl[sicp_pkg::IX_LOCK],               // see R18
                   pins.lvl[sicp_pkg::IX_CMP + 2],            // see R19
                   pins.lvl[sicp_pkg::IX_CMP + 1],
                   pins.lvl[sicp_pkg::IX_CMP],
                   level};                                    // see R20

  // Bus state machine and settings; STOP or START abandons any byte
  always_comb
  begin
    nxt_q       = q_ff;
    nxt_q.scl_d = scl;
    nxt_q.sda_d = sda;
    if (stop_ev)
    begin
      nxt_q.st     = sicp_pkg::ST_IDLE;                       // see R8
      nxt_q.sda_oe = 1'b0;
      nxt_q.exp_kind = sicp_pkg::EXP_ANY;                     // see R9
    end
    else if (start_ev)
    begin
      nxt_q.st      = sicp_pkg::ST_ADDR;
      nxt_q.bit_cnt = 4'h0;
      nxt_q.sda_oe  = 1'b0;
      nxt_q.exp_kind = sicp_pkg::EXP_ANY;                     // see R9
    end
    else
    begin
      unique case (q_ff.st)
        sicp_pkg::ST_IDLE:
          nxt_q.st = sicp_pkg::ST_IDLE;
        sicp_pkg::ST_ADDR, sicp_pkg::ST_WR_BYTE:
        begin
          if (scl_rise && q_ff.bit_cnt < sicp_pkg::BYTE_DONE_CNT)
          begin
            nxt_q.shreg   = {q_ff.shreg[6:0], sda};
            nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
          end
          if (byte_done && q_ff.st == sicp_pkg::ST_ADDR)
          begin
            if (addr_match(q_ff.shreg, pins.lvl[sicp_pkg::IX_ADDR +: 2]))
            begin
              nxt_q.st     = sicp_pkg::ST_ACK_ADDR;           // see R2
              nxt_q.sda_oe = 1'b1;                            // see R3
              nxt_q.rw     = q_ff.shreg[sicp_pkg::RW_BIT];    // see R1
            end
            else
              nxt_q.st = sicp_pkg::ST_IDLE;
          end
          else if (byte_done)
          begin
            nxt_q.st     = sicp_pkg::ST_ACK_WR;
            nxt_q.sda_oe = 1'b1;                              // see R4
            unique case (q_ff.exp_kind)
              sicp_pkg::EXP_LO:
              begin
                // Second ratio byte commits the pair
                nxt_q.ratio[14:0] = {q_ff.ratio_hi, q_ff.shreg}; // see R7
                nxt_q.exp_kind    = sicp_pkg::EXP_ANY;        // see R6
              end
              sicp_pkg::EXP_BAND:
              begin
                nxt_q.test = q_ff.shreg[sicp_pkg::BND_TEST_HI:
                                        sicp_pkg::BND_TEST_LO]; // see R14
                nxt_q.band_second = q_ff.shreg[sicp_pkg::BND_SECOND];
                nxt_q.band_first  = q_ff.shreg[sicp_pkg::BND_FIRST]; // see R15
                nxt_q.exp_kind    = sicp_pkg::EXP_ANY;        // see R6
              end
              default:
              begin
                if (!q_ff.shreg[sicp_pkg::KIND_BIT])          // see R5
                begin
                  // First ratio byte only waits in a shadow
                  nxt_q.ratio_hi = q_ff.shreg[6:0];           // see R10
                  nxt_q.exp_kind = sicp_pkg::EXP_LO;
                end
                else
                begin
                  nxt_q.ratio[15] =
                    q_ff.shreg[sicp_pkg::CTL_RATIO_TOP];      // see R10
                  nxt_q.pump = q_ff.shreg[sicp_pkg::CTL_PUMP_HI:
                                          sicp_pkg::CTL_PUMP_LO]; // see R11
                  nxt_q.ref_div =
                    q_ff.shreg[sicp_pkg::CTL_REF_DIV];        // see R12
                  nxt_q.amp_off =
                    q_ff.shreg[sicp_pkg::CTL_AMP_OFF];        // see R13
                  nxt_q.exp_kind = sicp_pkg::EXP_BAND;        // see R24
                end
              end
            endcase
          end
        end
        sicp_pkg::ST_ACK_ADDR:
          if (scl_fall)
          begin
            nxt_q.bit_cnt = 4'h0;
            nxt_q.sda_oe  = 1'b0;
            nxt_q.st      = sicp_pkg::ST_WR_BYTE;
            if (q_ff.rw)
            begin
              nxt_q.st      = sicp_pkg::ST_RD_BYTE;
              nxt_q.shreg   = status;
              nxt_q.sda_oe  = ~status[7];                     // see R24
              nxt_q.bit_cnt = 4'h1;
            end
          end
        sicp_pkg::ST_ACK_WR:
          if (scl_fall)
          begin
            nxt_q.sda_oe  = 1'b0;
            nxt_q.bit_cnt = 4'h0;
            nxt_q.st      = sicp_pkg::ST_WR_BYTE;             // see R8
          end
        sicp_pkg::ST_RD_BYTE:
          if (scl_fall && q_ff.bit_cnt < sicp_pkg::BYTE_DONE_CNT)
          begin
            nxt_q.shreg   = {q_ff.shreg[6:0], 1'b0};
            nxt_q.sda_oe  = ~q_ff.shreg[6];                   // see R24
            nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            nxt_q.sda_oe = 1'b0;
            nxt_q.st     = sicp_pkg::ST_RD_ACK;
            if (pins.lvl[sicp_pkg::IX_SUPPLY])
              nxt_q.por = 1'b0;                               // see R17
          end
        sicp_pkg::ST_RD_ACK:
          if (scl_rise && sda)
            nxt_q.st = sicp_pkg::ST_IDLE;
          else if (scl_fall)
          begin
            // Master acked: send the status byte again
            nxt_q.st      = sicp_pkg::ST_RD_BYTE;
            nxt_q.shreg   = status;
            nxt_q.sda_oe  = ~status[7];
            nxt_q.bit_cnt = 4'h1;
          end
        default:
          nxt_q.st = sicp_pkg::ST_IDLE;
      endcase
    end
    // Supply loss sets the flag and wins over a clear
    if (!pins.lvl[sicp_pkg::IX_SUPPLY])
      nxt_q.por = 1'b1;                                       // see R17
    nxt_q.mode    = test_decode(nxt_q.test);                  // see R21
    nxt_q.amp_eff = nxt_q.amp_off & ~(|nxt_q.mode);           // see R23
  end

  // Settings start from their documented power-up values
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
      q_ff <= '{st: sicp_pkg::ST_IDLE, exp_kind: sicp_pkg::EXP_ANY,
                rw: 1'b0, shreg: 8'h00, bit_cnt: 4'h0, sda_oe: 1'b0,
                scl_d: 1'b1, sda_d: 1'b1, ratio_hi: 7'h00,
                ratio: sicp_pkg::RST_RATIO, pump: sicp_pkg::RST_PUMP,
                ref_div: sicp_pkg::RST_REF_DIV,
                amp_off: sicp_pkg::RST_AMP_OFF,
                amp_eff: sicp_pkg::RST_AMP_OFF,
                test: sicp_pkg::RST_TEST, mode: 6'h00,
                band_first: sicp_pkg::RST_BAND,
                band_second: sicp_pkg::RST_BAND,
                por: sicp_pkg::RST_POR};                      // see R25
    else
      q_ff <= nxt_q;
  end

  // Outputs straight from the state register; SDA_OUT is tied low
  assign SDA_OUT               = 1'b0;
  assign SDA_OE_OUT            = q_ff.sda_oe;
  assign RATIO_OUT             = q_ff.ratio;
  assign PUMP_CURRENT_OUT      = q_ff.pump;
  assign REF_DIVIDE_SELECT_OUT = q_ff.ref_div;
  assign TUNING_AMP_OFF_OUT    = q_ff.amp_eff;
  assign TEST_SEL_OUT          = q_ff.test;
  assign PUMP_OFF_OUT          = q_ff.mode[0];
  assign SINK_ONLY_OUT         = q_ff.mode[1];
  assign SOURCE_ONLY_OUT       = q_ff.mode[2];
  assign REF_MONITOR_OUT       = q_ff.mode[3];
  assign HALF_DIV_MONITOR_OUT  = q_ff.mode[4];
  assign PHASE_TEST_OUT        = q_ff.mode[5];
  assign BAND_OUT_FIRST_OUT    = q_ff.band_first;
  assign BAND_OUT_SECOND_OUT   = q_ff.band_second;

  // Checks on the bus sequencing and the settings
  a_read_select: assert property (@(posedge CORE_CLK_IN) // see R1
    disable iff (!RST_N_IN)
    $rose(q_ff.st == sicp_pkg::ST_RD_BYTE) && $past(q_ff.st) ==
      sicp_pkg::ST_ACK_ADDR |-> q_ff.rw)
    else $error("read byte started on a write address");
  a_addr_ack: assert property (@(posedge CORE_CLK_IN) // see R3
    disable iff (!RST_N_IN)
    $rose(q_ff.st == sicp_pkg::ST_ACK_ADDR) |->
      q_ff.sda_oe && addr_match($past(q_ff.shreg),
                                $past(pins.lvl[3:2])))
    else $error("address ack without match or drive");
  a_write_ack: assert property (@(posedge CORE_CLK_IN) // see R4
    disable iff (!RST_N_IN)
    $rose(q_ff.st == sicp_pkg::ST_ACK_WR) |-> q_ff.sda_oe [*1] ##1
      (q_ff.sda_oe || q_ff.st != sicp_pkg::ST_ACK_WR))
    else $error("write byte not acknowledged");
  a_pair_update: assert property (@(posedge CORE_CLK_IN) // see R7
    disable iff (!RST_N_IN)
    $changed(q_ff.ratio[14:0]) |-> $past(q_ff.exp_kind) ==
      sicp_pkg::EXP_LO)
    else $error("ratio changed outside a byte pair");
  a_abort_hold: assert property (@(posedge CORE_CLK_IN) // see R9
    disable iff (!RST_N_IN)
    (start_ev || stop_ev) |=> $stable(q_ff.ratio) &&
      $stable(q_ff.band_first) && $stable(q_ff.test))
    else $error("settings changed on bus abort");
  a_band_latch: assert property (@(posedge CORE_CLK_IN) // see R15
    disable iff (!RST_N_IN)
    $changed(q_ff.band_first) || $changed(q_ff.band_second) |->
      $past(q_ff.exp_kind) == sicp_pkg::EXP_BAND &&
      q_ff.st == sicp_pkg::ST_ACK_WR)
    else $error("band output changed outside band byte");
  a_por_clear: assert property (@(posedge CORE_CLK_IN) // see R17
    disable iff (!RST_N_IN)
    $fell(q_ff.por) |-> $past(q_ff.st) == sicp_pkg::ST_RD_BYTE &&
      q_ff.st == sicp_pkg::ST_RD_ACK)
    else $error("power flag cleared without a read");
  a_amp_forced: assert property (@(posedge CORE_CLK_IN) // see R23
    disable iff (!RST_N_IN)
    (q_ff.test != 3'h0) |-> !TUNING_AMP_OFF_OUT && (|q_ff.mode))
    else $error("tuning amp off during test mode");

endmodule // sicp_control_port

//--- hw/sicp_pin_if.sv
`timescale 1ns/1ps
interface sicp_pin_if;
  logic [11:0] raw;  // Asynchronous pin levels
  logic [11:0] lvl;  // Filtered levels in the core clock domain
  modport sampler (input raw, output lvl);
  modport core    (output raw, input lvl);
endinterface

//--- hw/sicp_pin_sampler.sv
`timescale 1ns/1ps
module sicp_pin_sampler (
  input  wire logic      clk_in,   // Core clock
  input  wire logic      rst_n_in, // Synchronous reset, active low
  sicp_pin_if.sampler    pins      // Raw pins in, filtered levels out
);

  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] lvl;
  } sicp_sync_t;

  sicp_sync_t q_ff;
  sicp_sync_t nxt_q;

  // Level moves only when stages two and three agree; s1 feeds s2 only
  always_comb
  begin
    nxt_q     = q_ff;
    nxt_q.s1  = pins.raw;
    nxt_q.s2  = q_ff.s1;
    nxt_q.s3  = q_ff.s2;
    nxt_q.lvl = (~(q_ff.s2 ^ q_ff.s3) & q_ff.s3)
              | ((q_ff.s2 ^ q_ff.s3) & q_ff.lvl);
  end

  // Idle-high reset keeps a false START from appearing on release
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      q_ff <= '{s1: sicp_pkg::SYNC_RST, s2: sicp_pkg::SYNC_RST,
                s3: sicp_pkg::SYNC_RST, lvl: sicp_pkg::SYNC_RST};
    else
      q_ff <= nxt_q;
  end

  assign pins.lvl = q_ff.lvl;

endmodule // sicp_pin_sampler

//--- hw/sicp_pkg.sv
package sicp_pkg;

  // Fixed upper part of the seven-bit slave address
  localparam logic [4:0] ADDR_FIXED    = 5'h18;
  localparam int         BYTE_BITS     = 8;
  localparam logic [3:0] BYTE_DONE_CNT = 4'h8;

  // Field positions inside a received byte, MSB is index 7
  localparam int KIND_BIT      = 7;
  localparam int RW_BIT        = 0;
  localparam int CTL_RATIO_TOP = 5;
  localparam int CTL_PUMP_HI   = 4;
  localparam int CTL_PUMP_LO   = 3;
  localparam int CTL_REF_DIV   = 1;
  localparam int CTL_AMP_OFF   = 0;
  localparam int BND_TEST_HI   = 7;
  localparam int BND_TEST_LO   = 5;
  localparam int BND_SECOND    = 3;
  localparam int BND_FIRST     = 0;

  // Status byte layout, shifted out MSB first
  localparam int STS_POR  = 7;
  localparam int STS_LOCK = 6;
  localparam int STS_CMP3 = 5;
  localparam int STS_CMP2 = 4;
  localparam int STS_CMP1 = 3;
  localparam int STS_LVL  = 0;

  // Top converter code; anything above it is clamped
  localparam logic [2:0] LEVEL_MAX = 3'h4;

  // Test mode codes
  localparam logic [2:0] TM_REF    = 3'h4;
  localparam logic [2:0] TM_HALF   = 3'h5;
  localparam logic [2:0] TM_SINK   = 3'h6;
  localparam logic [2:0] TM_SOURCE = 3'h7;
  localparam logic [2:0] TM_PHASE  = 3'h1;

  // Values after reset
  localparam logic [15:0] RST_RATIO   = 16'h0000;
  localparam logic [1:0]  RST_PUMP    = 2'h0;
  localparam logic        RST_REF_DIV = 1'h0;
  localparam logic        RST_AMP_OFF = 1'h1;
  localparam logic [2:0]  RST_TEST    = 3'h0;
  localparam logic        RST_BAND    = 1'h0;
  localparam logic        RST_POR     = 1'h1;

  // Pin sampler vector positions
  localparam int         SYNC_W    = 12;
  localparam int         IX_SCL    = 0;
  localparam int         IX_SDA    = 1;
  localparam int         IX_ADDR   = 2;
  localparam int         IX_LOCK   = 4;
  localparam int         IX_CMP    = 5;
  localparam int         IX_LVL    = 8;
  localparam int         IX_SUPPLY = 11;
  localparam logic [11:0] SYNC_RST = 12'hFFF;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR_BYTE, ST_ACK_WR,
    ST_RD_BYTE, ST_RD_ACK
  } sicp_bus_t;

  typedef enum logic [1:0] {EXP_ANY, EXP_LO, EXP_BAND} sicp_exp_t;

endpackage

//--- verif/sicp_bus_master.sv
`timescale 1ns/1ps
module sicp_bus_master (
  input  wire logic clk_in,  // Core clock, paces the bus
  input  wire logic sda_in,  // Resolved data wire
  output logic      scl_out, // Bus clock, stands high between frames
  output logic      sda_out  // Low pulls data down, high releases
);
  // Bus idles released
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Wait a number of core clocks
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One bit, 124 ns: data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    w(8);
    sda_out <= b;
    w(8);
    scl_out <= 1'b1;
    w(8);
    r = sda_in;
    w(7);
    scl_out <= 1'b0;
  endtask

  // Data falls while the clock is high
  task automatic start();
    w(8);
    sda_out <= 1'b0;
    w(8);
    scl_out <= 1'b0;
  endtask

  // Data rises while the clock is high; ends the data run
  task automatic stop();
    w(8);
    sda_out <= 1'b0;
    w(8);
    scl_out <= 1'b1;
    w(8);
    sda_out <= 1'b1;
    w(8);
  endtask

  // Byte out MSB first, then release for the ack slot
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; a high last flag leaves the ack slot released
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // sicp_bus_master

//--- verif/synth_i2c_control_port_bench.sv
`timescale 1ns/1ps
// Compare a design value with its expectation and count it
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module synth_i2c_control_port_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  sel = 2'h2;
  logic        lock = 1'b0;
  logic [2:0]  cmp = 3'h0;  // Ports 3, 2, 1
  logic [2:0]  lvl = 3'h0;
  logic        sup = 1'b1;
  logic        ack;
  logic [7:0]  rd;
  wire         scl, sda_m, sda_w, oe, so, refd, amp, b1, b2;
  wire  [15:0] ratio;
  wire  [1:0]  pump;
  wire  [2:0]  tsel;
  wire  [5:0]  tfl;         // Pump off, sink, source, ref, half, phase
  int          err_count = 0;
  int          tests_run = 0;

  // Open-drain wire with pull-up
  assign sda_w = sda_m & (oe ? so : 1'b1);
  always #2 clk = ~clk;

  sicp_control_port sicp_control_port_i (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda_w),
    .SDA_OUT(so), .SDA_OE_OUT(oe), .ADDR_SEL_IN(sel), .LOCK_FLAG_IN(lock),
    .COMPARATOR_IN_1_IN(cmp[0]), .COMPARATOR_IN_2_IN(cmp[1]),
    .COMPARATOR_IN_3_IN(cmp[2]), .LEVEL_CODE_IN(lvl), .SUPPLY_OK_IN(sup),
    .RATIO_OUT(ratio), .PUMP_CURRENT_OUT(pump),
    .REF_DIVIDE_SELECT_OUT(refd), .TUNING_AMP_OFF_OUT(amp),
    .TEST_SEL_OUT(tsel), .PUMP_OFF_OUT(tfl[5]), .SINK_ONLY_OUT(tfl[4]),
    .SOURCE_ONLY_OUT(tfl[3]), .REF_MONITOR_OUT(tfl[2]),
    .HALF_DIV_MONITOR_OUT(tfl[1]), .PHASE_TEST_OUT(tfl[0]),
    .BAND_OUT_FIRST_OUT(b1), .BAND_OUT_SECOND_OUT(b2)
  );
  sicp_bus_master sicp_bus_master_i (
    .clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m)
  );

  // Address a transfer; the low bit picks read or write
  task automatic open_xfer(input logic rw);
    sicp_bus_master_i.start();
    sicp_bus_master_i.byte_wr({sicp_pkg::ADDR_FIXED, sel, rw}, ack);
    `CHK("addr ack", 1'b1, ack)
  endtask

  // One data byte, always acknowledged
  task automatic wr(input logic [7:0] d);
    sicp_bus_master_i.byte_wr(d, ack);
    `CHK("data ack", 1'b1, ack)
  endtask

  // Settings before any write
  task automatic t_reset();
    `CHK("ratio", 16'h0000, ratio)
    `CHK("bands", 2'h0, {b1, b2})
    `CHK("amp off", 1'b1, amp)
    `CHK("pump", 2'h0, pump)
  endtask

  // A foreign select value is ignored, the own one answered
  task automatic t_addr();
    sicp_bus_master_i.start();
    sicp_bus_master_i.byte_wr({sicp_pkg::ADDR_FIXED, ~sel, 1'b0}, ack);
    `CHK("foreign ack", 1'b0, ack)
    sicp_bus_master_i.stop();
    @(posedge clk);
    sel <= 2'h1;
    open_xfer(1'b0);
    sicp_bus_master_i.stop();
  endtask

  // Pair, control, band, don't-care bits, sweep and all pump codes
  task automatic t_write();
    open_xfer(1'b0);
    wr(8'h12);
    `CHK("ratio half", 16'h0000, ratio)
    wr(8'h34);
    `CHK("ratio", 16'h1234, ratio)
    wr(8'hB9);
    `CHK("ratio top", 16'h9234, ratio)
    `CHK("ctl", 4'hD, {pump, refd, amp})
    wr(8'h09);
    `CHK("bands", 2'h3, {b1, b2})
    wr(8'hC2);
    `CHK("ctl dc", 4'h2, {pump, refd, amp})
    wr(8'h1E);
    `CHK("band second", 2'h1, {b1, b2})
    wr(8'h05);
    wr(8'h67);
    `CHK("sweep", 16'h0567, ratio)
    for (int p = 0; p < 4; p++)
    begin
      wr({3'h4, p[1:0], 3'h0});
      wr(8'h00);
      `CHK("pump", p[1:0], pump)
    end
    sicp_bus_master_i.stop();
  endtask

  // Every test code; any active one forces the amp control to normal
  task automatic t_test();
    logic [2:0] c;
    logic [5:0] e;
    open_xfer(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      e = {c[2:1] == 2'h1, c == 3'h6, c == 3'h7, c == 3'h4,
           c == 3'h5, c == 3'h1};
      wr(8'h81);
      wr({c, 5'h00});
      `CHK("test", c, tsel)
      `CHK("flags", e, tfl)
      `CHK("amp", c == 3'h0, amp)
    end
    sicp_bus_master_i.stop();
  endtask

  // Stop inside a pair drops the half pair; a new frame starts clean
  task automatic t_abort();
    open_xfer(1'b0);
    wr(8'h0A);
    for (int i = 0; i < 3; i++)
      sicp_bus_master_i.bit_io(1'b1, ack);
    sicp_bus_master_i.stop();
    `CHK("abort", 16'h0567, ratio)
    open_xfer(1'b0);
    wr(8'h01);
    wr(8'h02);
    `CHK("after abort", 16'h0102, ratio)
    sicp_bus_master_i.stop();
  endtask

  // Read one status byte, master refuses more
  task automatic rd_chk(input logic [7:0] e);
    open_xfer(1'b1);
    sicp_bus_master_i.byte_rd(1'b1, rd);
    sicp_bus_master_i.stop();
    `CHK("status", e, rd)
  endtask

  // Status fields, power flag cleared by a read and set by supply loss
  task automatic t_status();
    @(posedge clk);
    lock <= 1'b1;
    cmp <= 3'h6;
    lvl <= 3'h3;
    rd_chk(8'hF3);
    lock <= 1'b0;
    cmp <= 3'h1;
    lvl <= 3'h4;
    rd_chk(8'h0C);
    sup <= 1'b0;
    repeat (8) @(posedge clk);
    sup <= 1'b1;
    cmp <= 3'h0;
    lvl <= 3'h7;
    rd_chk(8'h84);
    lvl <= 3'h0;
    rd_chk(8'h00);
  endtask

  // Print the counts and the verdict, then end
  task automatic complete_run();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Reset for three cycles, let the pin sampler refill, then run
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_addr();
    t_write();
    t_test();
    t_abort();
    t_status();
    complete_run();
  end

  // Watchdog, well beyond the expected run of some 14300 clocks
  initial
  begin
    #300000;
    err_count++;
    complete_run();
  end
endmodule // synth_i2c_control_port_bench
